// ---- src/bps_pkg.sv ----
// Shared constants, register layouts and types of the bridge PWM output stage
package bps_pkg;

    // ****************************************************************
    // Register byte offsets (APB, one aligned word each)
    // ****************************************************************
    localparam logic [11:0] BPS_OFF_CTRL = 12'h000; // module_ctrl_reg
    localparam logic [11:0] BPS_OFF_DUTY = 12'h004; // duty_high_reg
    localparam logic [11:0] BPS_OFF_PERIOD = 12'h008; // period_reg
    localparam logic [11:0] BPS_OFF_DBR = 12'h00C; // deadband_restart_reg
    localparam logic [11:0] BPS_OFF_SDC = 12'h010; // shutdown_ctrl_reg
    localparam logic [11:0] BPS_OFF_TMRC = 12'h014; // period timer control
    localparam logic [11:0] BPS_OFF_STAT = 12'h018; // read-only status

    // ****************************************************************
    // Register layouts
    // ****************************************************************
    typedef struct packed {
        logic [1:0] out_mode;  // output_mode_field, bit 1 is direction_bit
        logic [1:0] duty_lo;   // two low duty bits
        logic [3:0] mode;      // [3:2]=11 enables, [1:0] polarity_bits
    } bps_ctrl_t;

    typedef struct packed {
        logic restart_en;      // auto_restart_enable
        logic [6:0] db_count;  // deadband_count in instruction cycles
    } bps_dbr_t;

    typedef struct packed {
        logic status;          // shutdown_status_bit
        logic [2:0] src_sel;   // shutdown_source_sel: [2] int pin, [1] cmp2, [0] cmp1
        logic [1:0] safe_ac;   // pair_ac_safe_state
        logic [1:0] safe_bd;   // pair_bd_safe_state
    } bps_sdc_t;

    typedef struct packed {
        logic on;              // timer run
        logic [1:0] presc;     // 00 = 1, 01 = 4, 1x = 16
    } bps_tmrc_t;

    // ****************************************************************
    // Reset values and encodings
    // ****************************************************************
    localparam bps_ctrl_t BPS_CTRL_RST = 8'h00;
    localparam bps_dbr_t BPS_DBR_RST = 8'h00;
    localparam bps_sdc_t BPS_SDC_RST = 8'h00;
    localparam bps_tmrc_t BPS_TMRC_RST = 3'h0;
    localparam logic [1:0] BPS_OM_SINGLE = 2'h0;
    localparam logic [1:0] BPS_OM_FWD = 2'h1;
    localparam logic [1:0] BPS_OM_HALF = 2'h2;
    localparam logic [1:0] BPS_OM_REV = 2'h3;
    localparam logic [1:0] BPS_MODE_PWM = 2'h3;
    localparam logic [1:0] BPS_SAFE_LOW = 2'h0;
    localparam logic [1:0] BPS_SAFE_HIGH = 2'h1;
    localparam logic [3:0] BPS_PRE_MAX1 = 4'h0;
    localparam logic [3:0] BPS_PRE_MAX4 = 4'h3;
    localparam logic [3:0] BPS_PRE_MAX16 = 4'hF;

    // ****************************************************************
    // Timing (system clock is Tosc = 10 ns)
    // ****************************************************************
    localparam int BPS_TOSC_NS = 10;
    localparam int BPS_TCY_NS = 4 * BPS_TOSC_NS;        // instr_cycle
    localparam int BPS_TCY_CLKS = BPS_TCY_NS / BPS_TOSC_NS;
    localparam logic [8:0] BPS_DIR_LEAD = 9'h004;       // timer counts

    // Enable sequencer, one-hot
    typedef enum logic [2:0] {
        BPS_ST_OFF = 3'b001,
        BPS_ST_WAIT = 3'b010,
        BPS_ST_RUN = 3'b100
    } bps_state_t;

endpackage : bps_pkg

// ---- src/bps_output_stage.sv ----
// Bridge PWM output stage with dead band, direction change and auto-shutdown
//
// What this block does
// - Period is 4 clocks times (period+1) times prescale
// - Pulse width is 10-bit duty times prescale clocks
// - Half-bridge: A modulated, B complement, C/D unused
// - Dead band counts instruction cycles before activation
// - Dead band only on inactive-to-active edges
// - Dead band longer than pulse keeps output inactive
// - Forward: A active, D modulated, B/C inactive
// - Reverse: C active, B modulated, A/D inactive
// - Direction bit writable anytime, applies next period
// - Four counts early: modulated off, unmodulated swapped
// - Full bridge uses no dead band
// - Source field picks int pin low, comparators high
// - Shutdown sets status bit until cleared
// - Shutdown forces pairs to high, low or float
// - Shutdown lasts while source level persists
// - Status writes ignored while source active
// - Restart only at next period start
// - Writing one to status forces shutdown
// - Auto-restart clears software set at once
// - Auto-restart clears status when source goes
// - Low mode bits set polarity per pair
// - First enable waits for a new period
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module bps_output_stage
    import bps_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic int_pin_n,
    input wire logic cmp1_out,
    input wire logic cmp2_out,
    output logic out_a,
    output logic out_b,
    output logic out_c,
    output logic out_d,
    output logic out_a_oe,
    output logic out_b_oe,
    output logic out_c_oe,
    output logic out_d_oe
);

    // ****************************************************************
    // Registers and state
    // ****************************************************************
    bps_ctrl_t ctrl_q;
    bps_dbr_t dbr_q;
    bps_sdc_t sdc_q;
    bps_tmrc_t tmrc_q;
    logic [7:0] duty_hi_q;
    logic [7:0] period_q;
    logic [31:0] prdata_q;
    logic [3:0] pre_q;
    logic [1:0] fine_q;
    logic [7:0] tmr_q;
    logic [9:0] duty_q;
    logic dir_q;
    logic pwm_q;
    logic [8:0] db_cnt_q;
    logic [3:0] act_q;
    logic hold_q;
    bps_state_t st_q;
    bps_state_t st_d;
    logic status_d;
    logic pwm_d;
    logic [3:0] act_d;

    // ****************************************************************
    // APB slave decode
    // ****************************************************************
    wire setup = psel && !penable;
    wire access = psel && penable;
    wire hit_ctrl = (paddr == BPS_OFF_CTRL);
    wire hit_duty = (paddr == BPS_OFF_DUTY);
    wire hit_per = (paddr == BPS_OFF_PERIOD);
    wire hit_dbr = (paddr == BPS_OFF_DBR);
    wire hit_sdc = (paddr == BPS_OFF_SDC);
    wire hit_tmrc = (paddr == BPS_OFF_TMRC);
    wire hit_stat = (paddr == BPS_OFF_STAT);
    wire hit_any = hit_ctrl | hit_duty | hit_per | hit_dbr | hit_sdc | hit_tmrc | hit_stat;
    wire wr_en = access && pwrite && hit_any;
    wire wr_sdc = wr_en && hit_sdc;
    wire force_out;
    wire [31:0] stat_word = {19'h0_0000, force_out, dir_q, (st_q == BPS_ST_RUN), fine_q, tmr_q};
    wire [31:0] rd_word = hit_ctrl ? {24'h00_0000, ctrl_q} :
                          hit_duty ? {24'h00_0000, duty_hi_q} :
                          hit_per ? {24'h00_0000, period_q} :
                          hit_dbr ? {24'h00_0000, dbr_q} :
                          hit_sdc ? {24'h00_0000, sdc_q} :
                          hit_tmrc ? {29'h0000_0000, tmrc_q} :
                          hit_stat ? stat_word : 32'h0000_0000;

    // Zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = access && !hit_any;
    assign prdata = prdata_q;

    // Read data captured in the setup phase
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata_q <= rd_word;
        end
    end

    // Plain configuration registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_q <= BPS_CTRL_RST;
            duty_hi_q <= 8'h00;
            period_q <= 8'h00;
            dbr_q <= BPS_DBR_RST;
            tmrc_q <= BPS_TMRC_RST;
        end else if (wr_en) begin
            if (hit_ctrl) ctrl_q <= pwdata[7:0];
            if (hit_duty) duty_hi_q <= pwdata[7:0];
            if (hit_per) period_q <= pwdata[7:0];
            if (hit_dbr) dbr_q <= pwdata[7:0];
            if (hit_tmrc) tmrc_q <= pwdata[2:0];
        end
    end

    // ****************************************************************
    // Time base: prescaler, 2-bit fine count and 8-bit period timer
    // ****************************************************************
    wire [3:0] pre_max = (tmrc_q.presc == 2'h0) ? BPS_PRE_MAX1 :
                         (tmrc_q.presc == 2'h1) ? BPS_PRE_MAX4 : BPS_PRE_MAX16;
    wire tick = tmrc_q.on && (pre_q == pre_max);
    wire tmr_step = tick && (fine_q == 2'h3);
    wire period_start = tmr_step && (tmr_q == period_q);
    wire [9:0] tbase = {tmr_q, fine_q};

    // Period timer advance
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pre_q <= 4'h0;
            fine_q <= 2'h0;
            tmr_q <= 8'h00;
        end else if (tmrc_q.on) begin
            pre_q <= tick ? 4'h0 : pre_q + 4'h1;
            if (tick) fine_q <= fine_q + 2'h1;
            if (tmr_step) tmr_q <= period_start ? 8'h00 : tmr_q + 8'h01;
        end
    end

    // Duty and direction latched at each period boundary
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            duty_q <= 10'h000;
            dir_q <= 1'b0;
        end else if (period_start) begin
            duty_q <= {duty_hi_q, ctrl_q.duty_lo};
            dir_q <= ctrl_q.out_mode[1];
        end
    end

    // ****************************************************************
    // Enable sequencer
    // ****************************************************************
    wire enabled = (ctrl_q.mode[3:2] == BPS_MODE_PWM);

    // Start only on a fresh period
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            BPS_ST_OFF: if (enabled) st_d = BPS_ST_WAIT;
            BPS_ST_WAIT: if (!enabled) st_d = BPS_ST_OFF;
                else if (period_start) st_d = BPS_ST_RUN;
            BPS_ST_RUN: if (!enabled) st_d = BPS_ST_OFF;
            default: st_d = BPS_ST_OFF;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) st_q <= BPS_ST_OFF;
        else st_q <= st_d;
    end

    // ****************************************************************
    // Modulator and dead band
    // ****************************************************************
    wire running = (st_q == BPS_ST_RUN);
    wire [8:0] db_clks = {dbr_q.db_count, 2'b00};
    wire db_done = (db_cnt_q >= db_clks);
    assign pwm_d = running && (st_d == BPS_ST_RUN) && (tbase < duty_q);

    // Counter restarts on every modulator edge
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pwm_q <= 1'b0;
            db_cnt_q <= 9'h000;
        end else begin
            pwm_q <= pwm_d;
            if (pwm_d != pwm_q) db_cnt_q <= 9'h000;
            else if (db_cnt_q != 9'h1FF) db_cnt_q <= db_cnt_q + 9'h001;
        end
    end

    // ****************************************************************
    // Output steering per mode, active-level logic; bit 0 is A
    // ****************************************************************
    wire full = ctrl_q.out_mode[0];
    wire dir_new = ctrl_q.out_mode[1];
    wire dir_zone = full && (dir_new != dir_q) &&
                    (({1'b0, tmr_q} + BPS_DIR_LEAD) > {1'b0, period_q});
    wire [3:0] used = (ctrl_q.out_mode == BPS_OM_SINGLE) ? 4'h1 :
                      (ctrl_q.out_mode == BPS_OM_HALF) ? 4'h3 : 4'hF;

    always_comb begin
        act_d = 4'h0;
        if (running) begin
            unique case (ctrl_q.out_mode)
                BPS_OM_SINGLE: act_d[0] = pwm_q;
                BPS_OM_HALF: begin
                    act_d[0] = pwm_q && db_done;
                    act_d[1] = !pwm_q && db_done;
                end
                default: begin
                    if (dir_zone) begin
                        act_d[0] = !dir_new;
                        act_d[2] = dir_new;
                    end else if (!dir_q) begin
                        act_d[0] = 1'b1;
                        act_d[3] = pwm_q;
                    end else begin
                        act_d[2] = 1'b1;
                        act_d[1] = pwm_q;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) act_q <= 4'h0;
        else act_q <= act_d;
    end

    // ****************************************************************
    // Auto-shutdown
    // ****************************************************************
    wire [2:0] src_lvl = {!int_pin_n, cmp2_out, cmp1_out};
    wire src_act = |(sdc_q.src_sel & src_lvl);

    // Status bit: hardware set wins over any write
    always_comb begin
        status_d = sdc_q.status;
        if (wr_sdc) status_d = pwdata[7];
        if (sdc_q.status && dbr_q.restart_en && !src_act) status_d = 1'b0;
        if (src_act) status_d = 1'b1;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sdc_q <= BPS_SDC_RST;
            hold_q <= 1'b0;
        end else begin
            sdc_q.status <= status_d;
            if (wr_sdc) sdc_q[6:0] <= pwdata[6:0];
            if (status_d || src_act) hold_q <= 1'b1;
            else if (period_start) hold_q <= 1'b0;
        end
    end

    // Source level forces pins without waiting for a clock edge
    assign force_out = src_act || sdc_q.status || hold_q;

    // ****************************************************************
    // Pin drivers: polarity, safe states, enables
    // ****************************************************************
    wire pol_ac = ctrl_q.mode[1];
    wire pol_bd = ctrl_q.mode[0];
    wire [3:0] pol = {pol_bd, pol_ac, pol_bd, pol_ac};
    wire [3:0] pin_norm = act_q ^ pol;
    wire [1:0] safe_ac = sdc_q.safe_ac;
    wire [1:0] safe_bd = sdc_q.safe_bd;
    wire [3:0] safe_lvl = {safe_bd == BPS_SAFE_HIGH, safe_ac == BPS_SAFE_HIGH,
                           safe_bd == BPS_SAFE_HIGH, safe_ac == BPS_SAFE_HIGH};
    wire [3:0] safe_drv = {!safe_bd[1], !safe_ac[1], !safe_bd[1], !safe_ac[1]};
    wire [3:0] shut = {4{force_out && enabled}} & used;
    wire [3:0] pin_val = (shut & safe_lvl) | (~shut & pin_norm);
    wire [3:0] pin_oe = (shut & safe_drv) | (~shut & used & {4{enabled}});

    assign out_a = pin_val[0];
    assign out_b = pin_val[1];
    assign out_c = pin_val[2];
    assign out_d = pin_val[3];
    assign out_a_oe = pin_oe[0];
    assign out_b_oe = pin_oe[1];
    assign out_c_oe = pin_oe[2];
    assign out_d_oe = pin_oe[3];

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic [15:0] per_cnt_q;
    logic per_ok_q;
    wire [15:0] per_exp = ({8'h00, period_q} + 16'h0001) <<
                          ((tmrc_q.presc == 2'h0) ? 2 : (tmrc_q.presc == 2'h1) ? 4 : 6);
    wire half_run = running && (ctrl_q.out_mode == BPS_OM_HALF);

    // Clocks since the last period start, invalid after any write to a mapped address
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            per_cnt_q <= 16'h0000;
            per_ok_q <= 1'b0;
        end else begin
            per_cnt_q <= period_start ? 16'h0000 : per_cnt_q + 16'h0001;
            if (wr_en) per_ok_q <= 1'b0;
            else if (period_start) per_ok_q <= 1'b1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    AST_PERIOD_LEN: assert property (
        period_start && per_ok_q && !wr_en |-> per_cnt_q + 16'h0001 == per_exp)
        else $error("period length wrong");
    AST_DUTY_CMP: assert property (
        running && $stable(st_q) ##1 running |-> pwm_q == ($past(tbase) < $past(duty_q)))
        else $error("pulse does not follow duty compare");
    AST_HALF_PAIR: assert property (
        half_run && $past(half_run) |-> !(act_q[0] && act_q[1]) && act_q[3:2] == 2'h0)
        else $error("half-bridge pair overlap or C/D driven");
    AST_DB_RISE: assert property (
        half_run && $rose(pwm_q) && dbr_q.db_count != 7'h00 && !wr_en |=> !act_q[0])
        else $error("dead band skipped on activation");
    AST_DB_FALL: assert property (
        half_run ##1 half_run && $fell(pwm_q) |=>
        !act_q[0] && (!act_q[1] || $past(dbr_q.db_count) == 7'h00))
        else $error("dead band applied on release");
    AST_FWD: assert property (
        running && ctrl_q.out_mode == BPS_OM_FWD && !dir_q && !dir_zone |=>
        act_q[0] && !act_q[1] && !act_q[2] && act_q[3] == $past(pwm_q))
        else $error("forward drive wrong");
    AST_REV: assert property (
        running && ctrl_q.out_mode == BPS_OM_REV && dir_q && !dir_zone |=>
        act_q[2] && !act_q[0] && !act_q[3] && act_q[1] == $past(pwm_q))
        else $error("reverse drive wrong");
    AST_DIR_ZONE: assert property (
        running && dir_zone && $stable(ctrl_q) |=> !act_q[1] && !act_q[3])
        else $error("modulated outputs active during direction change");
    AST_SD_SET: assert property (
        src_act |=> sdc_q.status)
        else $error("shutdown source did not set status");
    AST_SD_WRITE: assert property (
        src_act && wr_sdc && !pwdata[7] |=> sdc_q.status)
        else $error("status cleared while source active");
    AST_SAFE_LOW: assert property (
        force_out && enabled && sdc_q.safe_ac == BPS_SAFE_LOW |-> !out_a && out_a_oe)
        else $error("pair A/C not driven low in shutdown");
    AST_RESTART: assert property (
        $fell(hold_q) |-> $past(period_start))
        else $error("restart off a period boundary");

    COV_HALF_DB: cover property (half_run && $rose(act_q[1]));
    COV_DIR_CHG: cover property (dir_zone ##1 !dir_zone);
    COV_AUTO_RST: cover property (dbr_q.restart_en && $fell(sdc_q.status));

endmodule : bps_output_stage

`default_nettype wire

// ---- bench/bps_bridge_model.sv ----
// Behavioural model of the external power switch drivers on the four pins
`timescale 1ns/1ps
`default_nettype none

module bps_bridge_model (
    input wire logic clk_sys,
    input wire logic [3:0] drv,
    input wire logic [3:0] oe,
    output logic [3:0] pin,
    output int overlap
);
    // ****************************************************************
    // Pin resolution
    // ****************************************************************
    // Released pins fall to the board pull-downs
    assign pin = drv & oe;
    // Cycles with both half-bridge switches on (shoot-through)
    int overlap_q = 0;
    assign overlap = overlap_q;
    always @(posedge clk_sys) begin
        if (pin[0] && pin[1]) begin
            overlap_q <= overlap_q + 1;
        end
    end
endmodule : bps_bridge_model
`default_nettype wire

// ---- bench/bps_output_stage_test.sv ----
// Self-checking testbench of the bridge PWM output stage
`timescale 1ns/1ps
`default_nettype none

module bps_output_stage_test;
    import bps_pkg::*;
    logic clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, out_a, out_b, out_c, out_d;
    logic out_a_oe, out_b_oe, out_c_oe, out_d_oe;
    logic int_pin_n = 1, cmp1_out = 0, cmp2_out = 0;
    logic [3:0] pin;
    logic [31:0] rd;
    logic err;
    int overlap, mismatches = 0, num_checks = 0, cyc = 0, n, ov0;
    int hi[4];

    bps_output_stage u_dut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .int_pin_n(int_pin_n), .cmp1_out(cmp1_out), .cmp2_out(cmp2_out),
        .out_a(out_a), .out_b(out_b), .out_c(out_c), .out_d(out_d), .out_a_oe(out_a_oe),
        .out_b_oe(out_b_oe), .out_c_oe(out_c_oe), .out_d_oe(out_d_oe));
    bps_bridge_model u_model (.clk_sys(clk_sys), .drv({out_d, out_c, out_b, out_a}),
        .oe({out_d_oe, out_c_oe, out_b_oe, out_a_oe}), .pin(pin), .overlap(overlap));

    // ****************************************************************
    // Clock, timeout and shared tasks
    // ****************************************************************
    initial forever #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            mismatches++;
            end_of_test();
        end
    end
    task end_of_test();
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One APB transfer: setup, then access held until pready
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task idle(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : idle
    // High-cycle count of each pin over a window of k cycles
    task meas(input int k);
        hi = '{0, 0, 0, 0};
        repeat (k) begin
            @(posedge clk_sys);
            #1;
            hi[0] += (out_a === 1'b1);
            hi[1] += (out_b === 1'b1);
            hi[2] += (out_c === 1'b1);
            hi[3] += (out_d === 1'b1);
        end
    endtask : meas
    task rise(output int c);
        c = 0;
        while (out_a !== 1'b0 && c < 3000) begin
            idle(1);
            c++;
        end
        while (out_a !== 1'b1 && c < 3000) begin
            idle(1);
            c++;
        end
    endtask : rise
    task cnt4(input int a, input int b, input int c, input int d);
        chk("count_a", a, hi[0]);
        chk("count_b", b, hi[1]);
        chk("count_c", c, hi[2]);
        chk("count_d", d, hi[3]);
    endtask : cnt4

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_reset();
        apb(0, BPS_OFF_DBR, 0);
        chk("dbr_rst", 32'h0000_0000, rd);
        apb(0, BPS_OFF_SDC, 0);
        chk("sdc_rst", 32'h0000_0000, rd);
        chk("oe_rst", 4'h0, {out_d_oe, out_c_oe, out_b_oe, out_a_oe});
        apb(0, 12'h020, 0);
        chk("unmapped_err", 1'b1, err);
        chk("pready", 1'b1, pready);
    endtask : t_reset
    task t_single();
        apb(1, BPS_OFF_PERIOD, 32'h0000_000F);
        apb(1, BPS_OFF_DUTY, 32'h0000_000A);
        apb(1, BPS_OFF_TMRC, 32'h0000_0004);
        apb(1, BPS_OFF_CTRL, 32'h0000_000C);
        rise(n);
        chk("first_high", 1'b1, out_a);
        meas(64);
        chk("first_pulse", 40, hi[0]);
        rise(n);
        chk("period_p1", 64, n);
        meas(64);
        chk("duty_p1", 40, hi[0]);
        apb(1, BPS_OFF_TMRC, 32'h0000_0005);
        idle(600);
        rise(n);
        rise(n);
        chk("period_p4", 256, n);
        meas(256);
        chk("duty_p4", 160, hi[0]);
        apb(1, BPS_OFF_TMRC, 32'h0000_0006);
        rise(n);
        rise(n);
        chk("period_p16", 1024, n);
        meas(1024);
        chk("duty_p16", 640, hi[0]);
        apb(1, BPS_OFF_TMRC, 32'h0000_0004);
    endtask : t_single
    task t_half();
        apb(1, BPS_OFF_DBR, 32'h0000_0001);
        apb(1, BPS_OFF_CTRL, 32'h0000_008C);
        idle(200);
        ov0 = overlap;
        meas(64);
        cnt4(36, 20, 0, 0);
        chk("oe_half", 4'h3, {out_d_oe, out_c_oe, out_b_oe, out_a_oe});
        chk("overlap", ov0, overlap);
        apb(1, BPS_OFF_DBR, 32'h0000_000B);
        idle(200);
        meas(64);
        chk("db_long_a", 0, hi[0]);
        chk("db_long_b", 0, hi[1]);
        apb(1, BPS_OFF_DBR, 32'h0000_0001);
        apb(1, BPS_OFF_CTRL, 32'h0000_008F);
        idle(200);
        meas(64);
        chk("pol_a", 28, hi[0]);
        chk("pol_b", 44, hi[1]);
    endtask : t_half
    task t_full();
        apb(1, BPS_OFF_CTRL, 32'h0000_004C);
        idle(200);
        meas(64);
        cnt4(64, 0, 0, 40);
        apb(1, BPS_OFF_CTRL, 32'h0000_00CC);
        idle(150);
        meas(64);
        cnt4(0, 40, 64, 0);
        apb(0, BPS_OFF_STAT, 0);
        chk("dir_latched", 1'b1, rd[11]);
    endtask : t_full
    task t_shut();
        apb(1, BPS_OFF_CTRL, 32'h0000_008C);
        apb(1, BPS_OFF_SDC, 32'h0000_0016);
        idle(200);
        @(posedge clk_sys);
        cmp1_out <= 1;
        #1;
        chk("safe_a", 1'b1, out_a);
        chk("safe_b_oe", 1'b0, out_b_oe);
        chk("pin_b", 1'b0, pin[1]);
        apb(0, BPS_OFF_SDC, 0);
        chk("status_cmp1", 1'b1, rd[7]);
        apb(1, BPS_OFF_SDC, 32'h0000_0016);
        apb(0, BPS_OFF_SDC, 0);
        chk("clear_refused", 1'b1, rd[7]);
        cmp1_out <= 0;
        apb(0, BPS_OFF_SDC, 0);
        chk("status_sticky", 1'b1, rd[7]);
        apb(1, BPS_OFF_SDC, 32'h0000_0016);
        apb(0, BPS_OFF_SDC, 0);
        chk("status_clear", 1'b0, rd[7]);
        idle(200);
        meas(64);
        cnt4(36, 20, 0, 0);
        apb(1, BPS_OFF_SDC, 32'h0000_0042);
        int_pin_n <= 0;
        apb(0, BPS_OFF_SDC, 0);
        chk("status_int", 1'b1, rd[7]);
        chk("int_safe_a", 1'b0, out_a);
        int_pin_n <= 1;
        apb(1, BPS_OFF_SDC, 32'h0000_0006);
        apb(1, BPS_OFF_SDC, 32'h0000_0086);
        apb(0, BPS_OFF_SDC, 0);
        chk("status_sw", 1'b1, rd[7]);
        chk("sw_safe_a", 1'b1, out_a);
        chk("sw_safe_b_oe", 1'b0, out_b_oe);
        apb(1, BPS_OFF_SDC, 32'h0000_0006);
        apb(1, BPS_OFF_DBR, 32'h0000_0081);
        apb(1, BPS_OFF_SDC, 32'h0000_0086);
        apb(0, BPS_OFF_SDC, 0);
        chk("sw_auto_clear", 1'b0, rd[7]);
        apb(1, BPS_OFF_SDC, 32'h0000_0026);
        cmp2_out <= 1;
        apb(0, BPS_OFF_SDC, 0);
        chk("auto_held", 1'b1, rd[7]);
        cmp2_out <= 0;
        idle(5);
        apb(0, BPS_OFF_SDC, 0);
        chk("auto_clear", 1'b0, rd[7]);
        idle(200);
        meas(64);
        cnt4(36, 20, 0, 0);
    endtask : t_shut

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (12) @(posedge clk_sys);
        reset <= 0;
        t_reset();
        t_single();
        t_half();
        t_full();
        t_shut();
        end_of_test();
    end
endmodule : bps_output_stage_test
`default_nettype wire
